//--- hw/chg_cfg.svh
`ifndef CHG_CFG_SVH
`define CHG_CFG_SVH
// Status word timing
`define CHG_CLK_HZ          20000000
`define CHG_PERIOD_SLOW_US  1000000
`define CHG_PERIOD_FAST_US  40
`define CHG_SLOW_CYC        ((`CHG_CLK_HZ / 1000000) * `CHG_PERIOD_SLOW_US)
`define CHG_FAST_CYC        ((`CHG_CLK_HZ / 1000000) * `CHG_PERIOD_FAST_US)
`define CHG_PERIODS         4
// Line patterns, bit 3 is the first period, 1 means line pulled low
`define CHG_PAT_SLEEP       4'h0
`define CHG_PAT_FAULT       4'hC
`define CHG_PAT_COND        4'hF
`define CHG_PAT_CC          4'hE
`define CHG_PAT_CV          4'h8
`define CHG_PAT_NOBAT       4'hC
`endif

//--- hw/chg_pkg.sv
package chg_pkg;
    typedef enum logic [2:0] {
        CHG_SLEEP,
        CHG_COND,
        CHG_CC,
        CHG_CV,
        CHG_DONE,
        CHG_INHIBIT,
        CHG_FAULT
    } chg_state_t;

    typedef struct packed {
        logic supply_ok;
        logic cell_present;
        logic below_recharge;
        logic below_precond;
        logic at_regulation;
        logic term_current;
        logic overcurrent_fault;
        logic excess_voltage_fault;
        logic temp_low;
        logic temp_high;
        logic temp_over;
    } chg_sense_t;

    typedef struct packed {
        logic [3:0] pattern;
    } chg_word_t;
endpackage : chg_pkg

//--- hw/chg_ctrl.sv
`timescale 1ns/1ns
`include "chg_cfg.svh"
module chg_ctrl
    import chg_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Comparator inputs, asynchronous
    input  wire chg_sense_t sense_in,
    input  wire logic       fast_trickle_select,
    // Charger controls
    output logic            pass_on,
    output logic            trickle_double,
    output logic [2:0]      phase,
    // Open-drain status line
    input  wire logic       status_in,
    output logic            status_out,
    output logic            status_oe,
    // Status word sink
    input  wire logic       word_ready,
    output logic            word_valid,
    output chg_word_t       word_data
);

    localparam int SLOW_CYC = `CHG_SLOW_CYC;
    localparam int FAST_CYC = `CHG_FAST_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    chg_sense_t sense_m_r, sense_r;
    logic       t2x_m_r, t2x_r;

    always_ff @(posedge clock) begin
        sense_m_r <= sense_in;
        sense_r   <= sense_m_r;
        t2x_m_r   <= fast_trickle_select;
        t2x_r     <= t2x_m_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode strap and fast trickle latch
    logic strap_done_r, fast_mode_r, ot_latch_r;

    // Strap taken at the first synchronised sample after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_done_r <= 1'b0;
            fast_mode_r  <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            fast_mode_r  <= t2x_r;
        end
    end

    wire temp_ok = !sense_r.temp_low && !sense_r.temp_high;

    always_ff @(posedge clock) begin
        if (rst) begin
            ot_latch_r <= 1'b0;
        end else if (sense_r.temp_over) begin
            ot_latch_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Charge sequencer
    chg_state_t state_r, state_nxt;

    function automatic chg_state_t phase_from_cell(chg_sense_t s);
        if (!s.below_recharge) begin
            return CHG_DONE;
        end else if (s.below_precond) begin
            return CHG_COND;
        end else if (!s.at_regulation) begin
            return CHG_CC;
        end else begin
            return CHG_CV;
        end
    endfunction : phase_from_cell

    wire fault_now = sense_r.overcurrent_fault || sense_r.excess_voltage_fault
                     || sense_r.temp_over;

    always_comb begin
        state_nxt = state_r;
        if (!sense_r.supply_ok || !sense_r.cell_present) begin
            state_nxt = CHG_SLEEP;
        end else if (fault_now) begin
            state_nxt = CHG_FAULT;
        end else if (!temp_ok) begin
            state_nxt = CHG_INHIBIT;
        end else begin
            case (state_r)
                CHG_SLEEP, CHG_INHIBIT, CHG_FAULT: begin
                    state_nxt = phase_from_cell(sense_r);
                end
                CHG_COND: begin
                    if (!sense_r.below_precond) begin
                        state_nxt = CHG_CC;
                    end
                end
                CHG_CC: begin
                    if (sense_r.at_regulation) begin
                        state_nxt = CHG_CV;
                    end
                end
                CHG_CV: begin
                    if (sense_r.term_current) begin
                        state_nxt = CHG_DONE;
                    end
                end
                CHG_DONE: begin
                    if (sense_r.below_recharge) begin
                        state_nxt = phase_from_cell(sense_r);
                    end
                end
                default: state_nxt = CHG_SLEEP;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= CHG_SLEEP;
        end else if (strap_done_r) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pass device and trickle level
    logic pass_r, dbl_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            pass_r <= 1'b0;
            dbl_r  <= 1'b0;
            phase  <= 3'h0;
        end else begin
            pass_r <= (state_r == CHG_COND) || (state_r == CHG_CC)
                      || (state_r == CHG_CV);
            // Doubled when strapped fast or pin chooses it, unless latched off
            dbl_r  <= (state_r == CHG_COND) && (fast_mode_r || !t2x_r)
                      && !ot_latch_r;
            phase  <= 3'(state_r);
        end
    end

    assign pass_on        = pass_r;
    assign trickle_double = dbl_r;

    ////////////////////////////////////////////////////////////////////////////
    // Status word encoder
    function automatic logic [3:0] pattern_of(chg_state_t s, logic present);
        if (!present) begin
            return `CHG_PAT_NOBAT;
        end
        case (s)
            CHG_FAULT:   return `CHG_PAT_FAULT;
            CHG_COND:    return `CHG_PAT_COND;
            CHG_CC:      return `CHG_PAT_CC;
            CHG_CV:      return `CHG_PAT_CV;
            default:     return `CHG_PAT_SLEEP;
        endcase
    endfunction : pattern_of

    // Wide enough for the one-second count at the full clock rate
    logic [24:0] div_r;
    logic [1:0]  per_r;
    logic [3:0]  cur_pat_r;
    logic        tick;

    // One-cycle enable at each period end
    assign tick = (div_r == 25'(((fast_mode_r ? FAST_CYC : SLOW_CYC) - 1)));

    always_ff @(posedge clock) begin
        if (rst || !strap_done_r) begin
            div_r <= 25'h000_0000;
        end else if (tick) begin
            div_r <= 25'h000_0000;
        end else begin
            div_r <= div_r + 25'h000_0001;
        end
    end

    wire word_end = tick && (per_r == 2'(`CHG_PERIODS - 1));

    always_ff @(posedge clock) begin
        if (rst) begin
            per_r     <= 2'h0;
            cur_pat_r <= 4'h0;
        end else if (!strap_done_r) begin
            cur_pat_r <= 4'h0;
        end else if (tick) begin
            per_r <= per_r + 2'h1;
            if (word_end) begin
                cur_pat_r <= pattern_of(state_r, sense_r.cell_present);
            end
        end
    end

    // Line pulled low during an active period, released otherwise
    always_ff @(posedge clock) begin
        if (rst) begin
            status_out <= 1'b0;
            status_oe  <= 1'b0;
        end else begin
            status_out <= 1'b0;
            status_oe  <= cur_pat_r[2'(3 - per_r)];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry word buffer; a word arriving while both entries are full is dropped
    chg_word_t buf_q [2];
    logic      wr_ptr_r, rd_ptr_r;
    logic [1:0] cnt_r;
    wire       in_valid = word_end;
    wire       in_ready = (cnt_r != 2'h2);
    wire       pop      = word_valid && word_ready;
    wire       push     = in_valid && in_ready;

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_r].pattern <= pattern_of(state_r, sense_r.cell_present);
                wr_ptr_r <= !wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= !rd_ptr_r;
            end
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            word_valid <= 1'b0;
            word_data  <= '0;
        end else begin
            word_valid <= (cnt_r - 2'(pop)) != 2'h0 || push;
            if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
                word_data.pattern <= pattern_of(state_r, sense_r.cell_present);
            end else begin
                word_data <= pop ? buf_q[!rd_ptr_r] : buf_q[rd_ptr_r];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_done_no_pass: assert property (@(posedge clock) disable iff (rst)
        state_r == CHG_DONE |=> !pass_on) else $error("pass on after completion");
    a_done_holds: assert property (@(posedge clock) disable iff (rst)
        (state_r == CHG_DONE && sense_r.below_recharge == 1'b0 && sense_r.supply_ok
         && sense_r.cell_present && !fault_now && temp_ok) |=> state_r == CHG_DONE)
        else $error("left completion above recharge");
    a_supply_sleep: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && !sense_r.supply_ok) |=> state_r == CHG_SLEEP)
        else $error("no sleep on supply loss");
    a_inhibit_pass: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && !temp_ok && sense_r.supply_ok && sense_r.cell_present)
        |=> ##1 !pass_on) else $error("pass on outside window");
    a_fault_enter: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && sense_r.supply_ok && sense_r.cell_present && fault_now)
        |=> state_r == CHG_FAULT) else $error("fault not entered");
    a_cc_to_cv: assert property (@(posedge clock) disable iff (rst)
        (state_r == CHG_CC && state_nxt != CHG_CC && !fault_now && temp_ok
         && sense_r.supply_ok && sense_r.cell_present) |-> sense_r.at_regulation)
        else $error("left constant current early");
    a_ot_no_double: assert property (@(posedge clock) disable iff (rst)
        ot_latch_r |=> !trickle_double) else $error("double trickle after fault");
    a_period_len: assert property (@(posedge clock) disable iff (rst)
        (tick && fast_mode_r) |=> (!tick) [*8]) else $error("fast period too short");
    a_fast_period: assert property (@(posedge clock) disable iff (rst)
        (tick && fast_mode_r) |-> div_r == 25'(`CHG_FAST_CYC - 1))
        else $error("fast period length wrong");
    // Pass device, trickle level and mode strap
    a_fault_no_pass: assert property (@(posedge clock) disable iff (rst)
        state_r == CHG_FAULT |=> !pass_on)
        else $error("pass on during fault");
    a_sleep_no_pass: assert property (@(posedge clock) disable iff (rst)
        state_r == CHG_SLEEP |=> !pass_on)
        else $error("pass on during sleep");
    a_fast_double: assert property (@(posedge clock) disable iff (rst)
        (state_r == CHG_COND && fast_mode_r && !ot_latch_r) |=> trickle_double)
        else $error("fast mode without doubled trickle");
    a_strap_hold: assert property (@(posedge clock) disable iff (rst)
        strap_done_r |=> $stable(fast_mode_r))
        else $error("report mode changed after strap");
    // Phase transitions and the no-cell pattern, guarded against the higher priority conditions
    a_ov_fault: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && sense_r.supply_ok && sense_r.cell_present
         && sense_r.excess_voltage_fault) |=> state_r == CHG_FAULT)
        else $error("overvoltage fault not entered");
    a_nobat_sleep: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && !sense_r.cell_present) |=> state_r == CHG_SLEEP)
        else $error("no sleep without cell");
    a_nobat_pattern: assert property (@(posedge clock) disable iff (rst)
        (word_end && !sense_r.cell_present) |=> cur_pat_r == `CHG_PAT_NOBAT)
        else $error("wrong pattern without cell");
    a_cond_to_cc: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && state_r == CHG_COND && !sense_r.below_precond && !fault_now
         && temp_ok && sense_r.supply_ok && sense_r.cell_present)
        |=> state_r == CHG_CC) else $error("stayed in trickle above precondition");
    a_cv_to_done: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && state_r == CHG_CV && sense_r.term_current && !fault_now
         && temp_ok && sense_r.supply_ok && sense_r.cell_present)
        |=> state_r == CHG_DONE) else $error("no completion at termination");
    a_inhibit_resume: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && state_r == CHG_INHIBIT && temp_ok && !fault_now
         && sense_r.supply_ok && sense_r.cell_present)
        |=> state_r != CHG_INHIBIT) else $error("inhibit held inside window");
    a_done_restart: assert property (@(posedge clock) disable iff (rst)
        (strap_done_r && state_r == CHG_DONE && sense_r.below_recharge && !fault_now
         && temp_ok && sense_r.supply_ok && sense_r.cell_present)
        |=> (state_r == CHG_COND || state_r == CHG_CC || state_r == CHG_CV))
        else $error("no restart below recharge");
endmodule : chg_ctrl

//--- verification/chg_status_reader.sv
`timescale 1ns/1ns
module chg_status_reader
    import chg_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Open-drain status line
    input  wire logic        status_out,
    input  wire logic        status_oe,
    output logic             line,
    // Status word sink
    input  wire logic        word_valid,
    input  wire chg_word_t   word_data,
    output logic             word_ready,
    output logic [3:0]       last_pat,
    output logic [15:0]      n_words
);
    logic [2:0] stall_r;

    // Pull-up only, no LED load on the line while fast reports run
    assign line       = status_oe ? status_out : 1'b1;
    // Stalls half the time so the two-entry buffer has to hold words
    assign word_ready = stall_r[2];

    always_ff @(posedge clock) begin
        if (rst) begin
            stall_r  <= 3'h0;
            last_pat <= 4'h0;
            n_words  <= 16'h0000;
        end else begin
            stall_r <= stall_r + 3'h1;
            if (word_valid && word_ready) begin
                last_pat <= word_data.pattern;
                n_words  <= n_words + 16'h0001;
            end
        end
    end
endmodule : chg_status_reader

//--- verification/tb_top.sv
`timescale 1ns/1ns
`include "chg_cfg.svh"
module tb_top
    import chg_pkg::*;
;
    logic        clock;
    logic        rst;
    chg_sense_t  sn;
    logic        strap;
    logic        pass_on;
    logic        trickle_double;
    logic [2:0]  phase;
    logic        line;
    logic        status_out;
    logic        status_oe;
    logic        word_ready;
    logic        word_valid;
    chg_word_t   word_data;
    logic [3:0]  last_pat;
    logic [15:0] n_words;
    int          fail_count;
    int          n_compared;

    chg_ctrl u_dut (.clock(clock), .rst(rst), .sense_in(sn), .fast_trickle_select(strap),
        .pass_on(pass_on), .trickle_double(trickle_double), .phase(phase),
        .status_in(line), .status_out(status_out), .status_oe(status_oe),
        .word_ready(word_ready), .word_valid(word_valid), .word_data(word_data));

    chg_status_reader u_reader (.clock(clock), .rst(rst), .status_out(status_out),
        .status_oe(status_oe), .line(line), .word_valid(word_valid),
        .word_data(word_data), .word_ready(word_ready), .last_pat(last_pat),
        .n_words(n_words));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step

    // Sync latency plus state and output registers
    task automatic quick(input logic [2:0] ph, input logic pass);
        step(8);
        check(16'(phase), 16'(ph));
        check(16'(pass_on), 16'(pass));
    endtask : quick

    task automatic expect_state(input logic [2:0] ph, input logic pass, input logic [3:0] pat);
        logic [15:0] start;
        int          hi;
        int          k;
        quick(ph, pass);
        // Let a word taken before the state change drain first
        step(4);
        start = n_words;
        k = 0;
        while (n_words == start && k < 4000) begin
            step(1);
            k++;
        end
        if (k >= 4000) begin
            fail_count++;
            complete_run();
        end
        check(16'(last_pat), 16'(pat));
        // Full word of line levels: HI cycles equal inactive periods times period
        hi = 0;
        repeat (`CHG_FAST_CYC * `CHG_PERIODS) begin
            @(posedge clock);
            hi += int'(line === 1'b1);
        end
        check(16'(hi), 16'((4 - $countones(pat)) * `CHG_FAST_CYC));
        $display("Test done: phase %0d", ph);
    endtask : expect_state

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        n_compared = 0;
        rst   = 1'b1;
        strap = 1'b1;
        sn    = '0;
        sn.supply_ok      = 1'b1;
        sn.cell_present   = 1'b1;
        sn.below_recharge = 1'b1;
        sn.below_precond  = 1'b1;
        step(4);
        rst <= 1'b0;
        step(4);
        expect_state(3'h1, 1'b1, 4'hf);
        check(16'(trickle_double), 16'h0001);
        sn.below_precond <= 1'b0;
        expect_state(3'h2, 1'b1, 4'he);
        sn.at_regulation <= 1'b1;
        expect_state(3'h3, 1'b1, 4'h8);
        sn.below_recharge <= 1'b0;
        sn.term_current   <= 1'b1;
        expect_state(3'h4, 1'b0, 4'h0);
        sn.term_current  <= 1'b0;
        sn.at_regulation <= 1'b0;
        quick(3'h4, 1'b0);
        sn.below_recharge <= 1'b1;
        quick(3'h2, 1'b1);
        sn.temp_high <= 1'b1;
        expect_state(3'h5, 1'b0, 4'h0);
        sn.temp_high <= 1'b0;
        quick(3'h2, 1'b1);
        sn.overcurrent_fault <= 1'b1;
        expect_state(3'h6, 1'b0, 4'hc);
        sn.overcurrent_fault <= 1'b0;
        quick(3'h2, 1'b1);
        sn.excess_voltage_fault <= 1'b1;
        quick(3'h6, 1'b0);
        sn.excess_voltage_fault <= 1'b0;
        quick(3'h2, 1'b1);
        sn.supply_ok <= 1'b0;
        expect_state(3'h0, 1'b0, 4'h0);
        sn.supply_ok <= 1'b1;
        quick(3'h2, 1'b1);
        sn.cell_present <= 1'b0;
        expect_state(3'h0, 1'b0, 4'hc);
        sn.cell_present <= 1'b1;
        sn.temp_over    <= 1'b1;
        quick(3'h6, 1'b0);
        sn.temp_over     <= 1'b0;
        sn.below_precond <= 1'b1;
        quick(3'h1, 1'b1);
        check(16'(trickle_double), 16'h0000);
        sn.below_precond <= 1'b0;
        quick(3'h2, 1'b1);
        // Second reset with the strap low: slow reports, low pin picks 2X
        rst              <= 1'b1;
        strap            <= 1'b0;
        sn.below_precond <= 1'b1;
        step(4);
        rst <= 1'b0;
        quick(3'h1, 1'b1);
        check(16'(trickle_double), 16'h0001);
        step(3300);
        check(n_words, 16'h0000);
        check(16'(status_oe), 16'h0000);
        $display("Test done: slow strap");
        complete_run();
    end
endmodule : tb_top
